// [src/ixo_pkg.sv]
// Constants for the indexed-offset operand execution block
package ixo_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DADDR_W = 12;
  localparam int MEM_DEPTH = 4096;
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int FLAG_W = 5;
  localparam int BANK_W = 4;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_INSTR = 8'h00;
  localparam logic [7:0] REG_WACC = 8'h04;
  localparam logic [7:0] REG_SFP = 8'h08;
  localparam logic [7:0] REG_BANK = 8'h0c;
  localparam logic [7:0] REG_FLAGS = 8'h10;
  localparam logic [7:0] REG_EADDR = 8'h14;
  localparam logic [7:0] REG_MADDR = 8'h18;
  localparam logic [7:0] REG_MDATA = 8'h1c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FLG_C = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N = 4;
  localparam int EADDR_IDX_BIT = 16;
  localparam int EADDR_FUSE_BIT = 17;
  localparam int OP_DEST_BIT = 9;
  localparam int OP_ACC_BIT = 8;

  // ----------------------------------------------------------------
  // Opcodes and operand limits
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC_ADD = 6'h09;
  localparam logic [3:0] OPC_BSET = 4'h8;
  localparam logic [7:0] OPC_FILL = 8'h86;
  localparam logic [7:0] FILL_VALUE = 8'hff;
  localparam logic [7:0] INDEX_LIMIT = 8'h5f;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_INSTR = 16'h0000;
  localparam logic [7:0] RST_WACC = 8'h00;
  localparam logic [DADDR_W-1:0] RST_SFP = 12'h000;
  localparam logic [BANK_W-1:0] RST_BANK = 4'h0;
  localparam logic [FLAG_W-1:0] RST_FLAGS = 5'h00;
  localparam logic [DADDR_W-1:0] RST_MADDR = 12'h000;
  localparam logic RST_FUSE = 1'b0;

  // ----------------------------------------------------------------
  // AXI responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [src/ixo_alu_if.sv]
// Carrier between the core and its address/arithmetic unit
`timescale 1ns/1ns
interface ixo_alu_if;
  logic fuse;
  logic acc_bit;
  logic [7:0] operand;
  logic [ixo_pkg::DADDR_W-1:0] sfp;
  logic [ixo_pkg::BANK_W-1:0] bank;
  logic [7:0] wacc;
  logic [7:0] mem_byte;
  logic [ixo_pkg::DADDR_W-1:0] eff_addr;
  logic indexed;
  logic [7:0] sum;
  logic [ixo_pkg::FLAG_W-1:0] flags;

  modport core (
    output fuse, acc_bit, operand, sfp, bank, wacc, mem_byte,
    input eff_addr, indexed, sum, flags
  );
  modport unit (
    input fuse, acc_bit, operand, sfp, bank, wacc, mem_byte,
    output eff_addr, indexed, sum, flags
  );
endinterface

// [src/ixo_exec_unit.sv]
// Effective address former and byte adder with status flags
`timescale 1ns/1ns
module ixo_exec_unit (
  ixo_alu_if.unit alu // Operands in, address and sum out
);
  logic [8:0] sum9;
  logic [4:0] half5;

  always_comb
  begin
    alu.indexed = alu.fuse & ~alu.acc_bit & (alu.operand <= ixo_pkg::INDEX_LIMIT);
    if (alu.indexed)
    begin
      // Wraps within the 4 KB data space
      alu.eff_addr = alu.sfp + {4'h0, alu.operand};
    end
    else if (alu.acc_bit)
    begin
      alu.eff_addr = {alu.bank, alu.operand};
    end
    else if (alu.operand <= ixo_pkg::INDEX_LIMIT)
    begin
      alu.eff_addr = {4'h0, alu.operand};
    end
    else
    begin
      alu.eff_addr = {ixo_pkg::ACCESS_HIGH_BANK, alu.operand};
    end
    sum9 = {1'b0, alu.wacc} + {1'b0, alu.mem_byte};
    half5 = {1'b0, alu.wacc[3:0]} + {1'b0, alu.mem_byte[3:0]};
    alu.sum = sum9[7:0];
    alu.flags = '0;
    alu.flags[ixo_pkg::FLG_C] = sum9[8];
    alu.flags[ixo_pkg::FLG_DC] = half5[4];
    alu.flags[ixo_pkg::FLG_Z] = (sum9[7:0] == 8'h00);
    alu.flags[ixo_pkg::FLG_N] = sum9[7];
    alu.flags[ixo_pkg::FLG_OV] = (alu.wacc[7] == alu.mem_byte[7]) && (sum9[7] != alu.wacc[7]);
  end
endmodule

// [src/ixo_indexed_exec.sv]
// Indexed-offset byte and bit instruction executor with AXI4-Lite access
//
// Summary of operation
// - With extension on, access operands up to 5Fh are offsets from the frame pointer.
// - Add-to-indexed sums accumulator with byte at frame pointer plus offset 0..95.
// - Destination bit zero keeps sum in accumulator; one writes it back to memory.
// - Add-to-indexed updates negative, overflow, carry, digit carry and zero flags.
// - Add opcode is 001001, d, 0, 8-bit offset; one word, one cycle.
// - Bit-set-indexed 1000 bbb0 kkkkkkkk sets bit b at indexed byte, except b = 3 (fill); flags unchanged.
// - Fill-indexed 1000 0110 kkkkkkkk writes FFh to indexed byte; flags unchanged.
// - Extension fuse defaults to zero, disabling extension and indexed addressing.
// - Offset mode only with access bit zero and operand up to 5Fh; else literal.
`timescale 1ns/1ns
module ixo_indexed_exec (
  input wire logic core_clk, // Core clock, 100 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic extension_enable_fuse, // Configuration fuse level
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] data_mem [ixo_pkg::MEM_DEPTH];
  logic [15:0] instr_r, instr_nxt;
  logic [7:0] wacc_r, wacc_nxt;
  logic [ixo_pkg::DADDR_W-1:0] sfp_r, sfp_nxt;
  logic [ixo_pkg::BANK_W-1:0] bank_r, bank_nxt;
  logic [ixo_pkg::FLAG_W-1:0] flags_r, flags_nxt;
  logic [ixo_pkg::DADDR_W-1:0] eaddr_r, eaddr_nxt;
  logic eidx_r, eidx_nxt;
  logic [ixo_pkg::DADDR_W-1:0] maddr_r, maddr_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic fuse_s1_r, fuse_s2_r, fuse_s3_r, fuse_r, fuse_nxt;

  logic wr_fire, rd_fire, exec_go;
  logic [31:0] wmask, merged;
  logic [15:0] op;
  logic is_add, is_bset, is_fill;
  logic mem_we;
  logic [ixo_pkg::DADDR_W-1:0] mem_wa;
  logic [7:0] mem_wd;

  ixo_alu_if alu_bus ();

  ixo_exec_unit u_exec (
    .alu (alu_bus.unit)
  );

  // ----------------------------------------------------------------
  // Fuse synchroniser
  // ----------------------------------------------------------------
  // Fuse resets to zero, so the extension stays off until sensed set
  always_comb
  begin
    fuse_nxt = fuse_r;
    if (fuse_s2_r == fuse_s3_r)
    begin
      fuse_nxt = fuse_s3_r;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      fuse_s1_r <= ixo_pkg::RST_FUSE;
      fuse_s2_r <= ixo_pkg::RST_FUSE;
      fuse_s3_r <= ixo_pkg::RST_FUSE;
      fuse_r <= ixo_pkg::RST_FUSE;
    end
    else if (ce)
    begin
      fuse_s1_r <= extension_enable_fuse;
      fuse_s2_r <= fuse_s1_r;
      fuse_s3_r <= fuse_s2_r;
      fuse_r <= fuse_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // Address and data are taken together so a write is never half-held
  assign s_axi_awready = ce & s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
  assign s_axi_wready = s_axi_awready;
  assign s_axi_arready = ce & ~rvalid_r;
  assign wr_fire = s_axi_awready;
  assign rd_fire = s_axi_arready & s_axi_arvalid;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      wmask[i*8 +: 8] = {8{s_axi_wstrb[i]}};
    end
    merged = ({16'h0000, instr_r} & ~wmask) | (s_axi_wdata & wmask);
    op = merged[15:0];
    exec_go = wr_fire && (s_axi_awaddr == ixo_pkg::REG_INSTR);
    is_fill = (op[15:8] == ixo_pkg::OPC_FILL);
    is_bset = (op[15:12] == ixo_pkg::OPC_BSET) && !is_fill;
    is_add = (op[15:10] == ixo_pkg::OPC_ADD);
  end

  assign alu_bus.fuse = fuse_r;
  assign alu_bus.acc_bit = op[ixo_pkg::OP_ACC_BIT];
  assign alu_bus.operand = op[7:0];
  assign alu_bus.sfp = sfp_r;
  assign alu_bus.bank = bank_r;
  assign alu_bus.wacc = wacc_r;
  assign alu_bus.mem_byte = data_mem[alu_bus.eff_addr];

  // ----------------------------------------------------------------
  // Register and execution next state
  // ----------------------------------------------------------------
  always_comb
  begin
    instr_nxt = instr_r;
    wacc_nxt = wacc_r;
    sfp_nxt = sfp_r;
    bank_nxt = bank_r;
    flags_nxt = flags_r;
    eaddr_nxt = eaddr_r;
    eidx_nxt = eidx_r;
    maddr_nxt = maddr_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    mem_we = 1'b0;
    mem_wa = alu_bus.eff_addr;
    mem_wd = 8'h00;
    if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt = 1'b0;
    end
    if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt = 1'b0;
    end
    if (wr_fire)
    begin
      bvalid_nxt = 1'b1;
      bresp_nxt = ixo_pkg::RESP_OKAY;
      case (s_axi_awaddr)
        ixo_pkg::REG_INSTR: instr_nxt = op;
        ixo_pkg::REG_WACC: wacc_nxt = (wacc_r & ~wmask[7:0]) | (s_axi_wdata[7:0] & wmask[7:0]);
        ixo_pkg::REG_SFP:
          sfp_nxt = (sfp_r & ~wmask[11:0]) | (s_axi_wdata[11:0] & wmask[11:0]);
        ixo_pkg::REG_BANK: bank_nxt = (bank_r & ~wmask[3:0]) | (s_axi_wdata[3:0] & wmask[3:0]);
        ixo_pkg::REG_FLAGS:
          flags_nxt = (flags_r & ~wmask[4:0]) | (s_axi_wdata[4:0] & wmask[4:0]);
        ixo_pkg::REG_EADDR: bresp_nxt = ixo_pkg::RESP_OKAY;
        ixo_pkg::REG_MADDR:
          maddr_nxt = (maddr_r & ~wmask[11:0]) | (s_axi_wdata[11:0] & wmask[11:0]);
        ixo_pkg::REG_MDATA:
        begin
          mem_we = s_axi_wstrb[0];
          mem_wa = maddr_r;
          mem_wd = s_axi_wdata[7:0];
        end
        default: bresp_nxt = ixo_pkg::RESP_SLVERR;
      endcase
    end
    // A written opcode executes completely in this one cycle
    if (exec_go && (is_add || is_bset || is_fill))
    begin
      eaddr_nxt = alu_bus.eff_addr;
      eidx_nxt = alu_bus.indexed;
      if (is_add)
      begin
        flags_nxt = alu_bus.flags;
        if (!op[ixo_pkg::OP_DEST_BIT])
        begin
          wacc_nxt = alu_bus.sum;
        end
        else
        begin
          mem_we = 1'b1;
          mem_wd = alu_bus.sum;
        end
      end
      else if (is_fill)
      begin
        mem_we = 1'b1;
        mem_wd = ixo_pkg::FILL_VALUE;
      end
      else
      begin
        mem_we = 1'b1;
        mem_wd = alu_bus.mem_byte | (8'h01 << op[11:9]);
      end
    end
    if (rd_fire)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = ixo_pkg::RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      case (s_axi_araddr)
        ixo_pkg::REG_INSTR: rdata_nxt[15:0] = instr_r;
        ixo_pkg::REG_WACC: rdata_nxt[7:0] = wacc_r;
        ixo_pkg::REG_SFP: rdata_nxt[11:0] = sfp_r;
        ixo_pkg::REG_BANK: rdata_nxt[3:0] = bank_r;
        ixo_pkg::REG_FLAGS: rdata_nxt[4:0] = flags_r;
        ixo_pkg::REG_EADDR:
        begin
          rdata_nxt[11:0] = eaddr_r;
          rdata_nxt[ixo_pkg::EADDR_IDX_BIT] = eidx_r;
          rdata_nxt[ixo_pkg::EADDR_FUSE_BIT] = fuse_r;
        end
        ixo_pkg::REG_MADDR: rdata_nxt[11:0] = maddr_r;
        ixo_pkg::REG_MDATA: rdata_nxt[7:0] = data_mem[maddr_r];
        default: rresp_nxt = ixo_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      instr_r <= ixo_pkg::RST_INSTR;
      wacc_r <= ixo_pkg::RST_WACC;
      sfp_r <= ixo_pkg::RST_SFP;
      bank_r <= ixo_pkg::RST_BANK;
      flags_r <= ixo_pkg::RST_FLAGS;
      eaddr_r <= '0;
      eidx_r <= 1'b0;
      maddr_r <= ixo_pkg::RST_MADDR;
      bvalid_r <= 1'b0;
      bresp_r <= ixo_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= ixo_pkg::RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end
    else if (ce)
    begin
      instr_r <= instr_nxt;
      wacc_r <= wacc_nxt;
      sfp_r <= sfp_nxt;
      bank_r <= bank_nxt;
      flags_r <= flags_nxt;
      eaddr_r <= eaddr_nxt;
      eidx_r <= eidx_nxt;
      maddr_r <= maddr_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Data memory holds no reset: contents are software's to initialise
  always_ff @(posedge core_clk)
  begin
    if (ce && !srst && mem_we)
    begin
      data_mem[mem_wa] <= mem_wd;
    end
  end
endmodule

// [testbench/ixo_indexed_exec_properties.sv]
// Port-level properties of the indexed-offset executor
`timescale 1ns/1ns
module ixo_indexed_exec_properties (
  input wire logic core_clk, // Core clock
  input wire logic srst, // Synchronous reset
  input wire logic ce, // Clock enable
  input wire logic extension_enable_fuse, // Fuse level
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic [1:0] s_axi_rresp, // Read response
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // Fuse steadiness counter
  // ----------------------------------------------------------------
  // Counts enabled edges only, since the fuse synchroniser freezes with ce
  logic [2:0] fuse_cnt_r, fuse_cnt_nxt;
  logic fuse_last_r, fuse_last_nxt;
  logic rd_take;
  assign rd_take = s_axi_arvalid && s_axi_arready && s_axi_araddr == ixo_pkg::REG_EADDR;
  always_comb
  begin
    fuse_last_nxt = fuse_last_r;
    fuse_cnt_nxt = fuse_cnt_r;
    if (ce)
    begin
      fuse_last_nxt = extension_enable_fuse;
      if (extension_enable_fuse != fuse_last_r)
        fuse_cnt_nxt = 3'h0;
      else if (fuse_cnt_r != 3'h7)
        fuse_cnt_nxt = fuse_cnt_r + 3'h1;
    end
    if (srst)
    begin
      fuse_last_nxt = 1'b0;
      fuse_cnt_nxt = 3'h0;
    end
  end
  always_ff @(posedge core_clk)
  begin
    fuse_last_r <= fuse_last_nxt;
    fuse_cnt_r <= fuse_cnt_nxt;
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_WRITE_GATE: assert property (
    s_axi_awready == (ce && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
    else $error("write ready not tied to its gate");
  AST_AW_W_TOGETHER: assert property (s_axi_awready == s_axi_wready)
    else $error("address and data ready differ");
  AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write response not one cycle after accept");
  AST_BVALID_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  AST_READ_GATE: assert property (s_axi_arready == (ce && !s_axi_rvalid))
    else $error("read ready not tied to its gate");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after accept");
  AST_RVALID_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) ##1 1'b1)
    else $error("read data changed before rready");
  AST_RVALID_DROP: assert property (s_axi_rvalid && s_axi_rready && ce |=> !s_axi_rvalid)
    else $error("read data stayed after rready");
  AST_UNMAPPED: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1c
    |=> s_axi_rresp == ixo_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_FUSE_OFF: assert property (
    rd_take && fuse_cnt_r == 3'h7 && !fuse_last_r |=> !s_axi_rdata[17])
    else $error("extension seen on with fuse low");
  AST_FUSE_ON: assert property (
    rd_take && fuse_cnt_r == 3'h7 && fuse_last_r |=> s_axi_rdata[17])
    else $error("extension not seen with fuse high");
  cover property (s_axi_awvalid && s_axi_awready);
  cover property (rd_take && fuse_cnt_r == 3'h7 && fuse_last_r);
  cover property (s_axi_rvalid && s_axi_rresp == ixo_pkg::RESP_SLVERR);
endmodule

bind ixo_indexed_exec ixo_indexed_exec_properties u_props (
  .core_clk(core_clk), .srst(srst), .ce(ce), .extension_enable_fuse(extension_enable_fuse),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// [testbench/testbench.sv]
// Register-level bench for the indexed-offset executor
`timescale 1ns/1ns
module testbench;
  logic core_clk, srst, ce, fuse_lvl, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [1:0] last_bresp, last_rresp;
  int err_count, checks_done;
  logic [7:0] va[5] = '{8'h17, 8'hff, 8'h80, 8'h7f, 8'h08};
  logic [7:0] vb[5] = '{8'h20, 8'h01, 8'h80, 8'h01, 8'h08};
  logic [15:0] aop[4] = '{16'h865f, 16'h8660, 16'h8110, 16'h8600};
  logic [31:0] aex[4] = '{32'h3004f, 32'h20f60, 32'h20310, 32'h30ff0};
  ixo_indexed_exec u_dut (
    .core_clk(core_clk), .srst(srst), .ce(ce), .extension_enable_fuse(fuse_lvl),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask
  // A wait that used its whole bound ends the run
  task automatic hang(input int n);
    if (n >= 200)
    begin
      $display("mismatch handshake expected answer seen none");
      err_count++;
      print_verdict();
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge core_clk);
    for (n = 0; n < 200 && awready !== 1'b1; n++) @(posedge core_clk);
    hang(n);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(posedge core_clk);
    for (n = 0; n < 200 && bvalid !== 1'b1; n++) @(posedge core_clk);
    hang(n);
    last_bresp = bresp;
    bready <= 1'b0;
    // One idle edge keeps a following call from re-raising bready in this step
    @(posedge core_clk);
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge core_clk);
    for (n = 0; n < 200 && arready !== 1'b1; n++) @(posedge core_clk);
    hang(n);
    arvalid <= 1'b0;
    @(posedge core_clk);
    for (n = 0; n < 200 && rvalid !== 1'b1; n++) @(posedge core_clk);
    hang(n);
    check(name, exp, rdata);
    last_rresp = rresp;
    rready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic exec(input logic [15:0] op);
    axi_wr(ixo_pkg::REG_INSTR, {16'h0, op});
  endtask
  task automatic mem_wr(input logic [11:0] a, input logic [7:0] b);
    axi_wr(ixo_pkg::REG_MADDR, {20'h0, a});
    axi_wr(ixo_pkg::REG_MDATA, {24'h0, b});
  endtask
  task automatic mem_chk(input string name, input logic [11:0] a, input logic [7:0] exp);
    axi_wr(ixo_pkg::REG_MADDR, {20'h0, a});
    rd_chk(name, ixo_pkg::REG_MDATA, {24'h0, exp});
  endtask
  // Flag order N OV Z DC C, high bit first
  function automatic logic [4:0] add_flags(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    add_flags = {s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00,
      ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f, s[8]};
  endfunction
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] s;
    logic [7:0] acc;
    {srst, ce, fuse_lvl, awvalid, wvalid, bready, arvalid, rready} = 8'hc0;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    wstrb = 4'hf;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    rd_chk("eaddr reset", ixo_pkg::REG_EADDR, 32'h0);
    check("rresp okay", {30'h0, ixo_pkg::RESP_OKAY}, {30'h0, last_rresp});
    axi_wr(ixo_pkg::REG_SFP, 32'ha00);
    check("bresp okay", {30'h0, ixo_pkg::RESP_OKAY}, {30'h0, last_bresp});
    mem_wr(12'h02c, 8'h11);
    mem_wr(12'ha2c, 8'h20);
    axi_wr(ixo_pkg::REG_WACC, 32'h17);
    exec({ixo_pkg::OPC_ADD, 2'b00, 8'h2c});
    rd_chk("wacc literal", ixo_pkg::REG_WACC, 32'h28);
    rd_chk("eaddr literal", ixo_pkg::REG_EADDR, 32'h0002c);
    fuse_lvl <= 1'b1;
    repeat (8) @(posedge core_clk);
    for (int i = 0; i < 5; i++)
    begin
      mem_wr(12'ha2c, vb[i]);
      axi_wr(ixo_pkg::REG_WACC, {24'h0, va[i]});
      s = va[i] + vb[i];
      exec({ixo_pkg::OPC_ADD, i[0], 1'b0, 8'h2c});
      rd_chk("add wacc", ixo_pkg::REG_WACC, {24'h0, i[0] ? va[i] : s});
      mem_chk("add mem", 12'ha2c, i[0] ? s : vb[i]);
      rd_chk("add flags", ixo_pkg::REG_FLAGS, {27'h0, add_flags(va[i], vb[i])});
      rd_chk("add eaddr", ixo_pkg::REG_EADDR, 32'h30a2c);
    end
    axi_wr(ixo_pkg::REG_SFP, 32'hff0);
    axi_wr(ixo_pkg::REG_BANK, 32'h3);
    for (int i = 0; i < 4; i++)
    begin
      exec(aop[i]);
      rd_chk("eaddr select", ixo_pkg::REG_EADDR, aex[i]);
    end
    mem_chk("fill literal", 12'hf60, 8'hff);
    axi_wr(ixo_pkg::REG_SFP, 32'ha00);
    axi_wr(ixo_pkg::REG_FLAGS, 32'h15);
    mem_wr(12'ha0a, 8'h00);
    acc = 8'h00;
    // Bit 3 is skipped: its encoding is the fill opcode
    for (int b = 0; b < 8; b++)
      if (b != 3)
      begin
        exec({ixo_pkg::OPC_BSET, b[2:0], 1'b0, 8'h0a});
        acc[b] = 1'b1;
        mem_chk("bit set", 12'ha0a, acc);
      end
    rd_chk("flags bit set", ixo_pkg::REG_FLAGS, 32'h15);
    exec({ixo_pkg::OPC_FILL, 8'h2c});
    mem_chk("fill", 12'ha2c, 8'hff);
    rd_chk("flags fill", ixo_pkg::REG_FLAGS, 32'h15);
    rd_chk("unmapped", 8'h40, 32'h0);
    check("unmapped rresp", {30'h0, ixo_pkg::RESP_SLVERR}, {30'h0, last_rresp});
    axi_wr(8'h40, 32'h1);
    check("unmapped bresp", {30'h0, ixo_pkg::RESP_SLVERR}, {30'h0, last_bresp});
    ce <= 1'b0;
    fork
      // Last add had destination zero, so the accumulator holds its sum
      rd_chk("frozen read", ixo_pkg::REG_WACC, {24'h0, va[4] + vb[4]});
      begin
        repeat (4) @(posedge core_clk);
        ce <= 1'b1;
      end
    join
    print_verdict();
  end
endmodule
